/* src/mnx_pkg.sv */
// Package: opcodes, timing counts and carrier structs of the multiply/negate/no-op unit
package mnx_pkg;
  localparam logic [7:0] MNX_OPC_GRP_BYTE = 8'hf6;
  localparam logic [7:0] MNX_OPC_GRP_WORD = 8'hf7;
  localparam logic [7:0] MNX_OPC_NO_OP = 8'h90;
  localparam logic [2:0] MNX_EXT_MUL = 3'h4;
  localparam logic [2:0] MNX_EXT_NEG = 3'h3;
  // Clock counts of each instruction form (multiply takes the shortest count of its range)
  localparam logic [5:0] MNX_CYC_NEG_REG = 6'h03;
  localparam logic [5:0] MNX_CYC_NEG_MEM = 6'h0a;
  localparam logic [5:0] MNX_CYC_NEG_MEM_NARROW = 6'h0e;
  localparam logic [5:0] MNX_CYC_NOP = 6'h03;
  localparam logic [5:0] MNX_CYC_MULB_REG = 6'h1a;
  localparam logic [5:0] MNX_CYC_MULB_MEM = 6'h20;
  localparam logic [5:0] MNX_CYC_MULW_REG = 6'h23;
  localparam logic [5:0] MNX_CYC_MULW_MEM = 6'h29;
  localparam logic [5:0] MNX_CYC_MULW_MEM_NARROW = 6'h2d;
  localparam logic [15:0] MNX_NOP_IP_STEP = 16'h0001;

  // Request from the sequencer
  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] ext;
    logic is_mem;
    logic [15:0] operand;
    logic [15:0] acc;
    logic [15:0] ip;
  } mnx_req_t;

  // Results returned to the register file
  typedef struct packed {
    logic [15:0] acc;
    logic acc_we;
    logic [15:0] dext;
    logic dext_we;
    logic [15:0] opnd;
    logic opnd_we;
    logic opnd_to_mem;
    logic [15:0] ip;
    logic ip_we;
  } mnx_res_t;

  // Arithmetic flags: carry, parity, aux, zero, sign, overflow
  typedef struct packed {
    logic carry_flag;
    logic parity;
    logic aux;
    logic zero;
    logic sign;
    logic overflow_flag;
  } mnx_flags_t;
endpackage

/* src/mnx_cycle_timer.sv */
// Down counter that stretches an instruction to its documented clock count
`timescale 1ns/1ps
module mnx_cycle_timer
  import mnx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [5:0] count_i,
  output logic last_o
);
  logic [5:0] cnt_q;

  // Counter holds at zero when idle; last cycle is when it reaches one
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 6'h00;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_q <= count_i;
      end else if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end

  assign last_o = (cnt_q == 6'h01);
endmodule

/* src/mnx_exec_unit.sv */
// Execution unit for unsigned multiply, two's complement negate and no-operation
// How it works
// - Byte multiply (F6 /4) multiplies the 8-bit operand by acc_low_byte into the 16-bit accumulator_word.
// - Word multiply (F7 /4) multiplies by accumulator_word, high half to data_extension_word, low to accumulator_word.
// - Both multiply factors are treated as unsigned and zero extended.
// - After multiply carry_flag and overflow_flag are both 0 if the upper product half is zero, else 1.
// - Negate (F6 /3, F7 /3) takes a register or memory operand and writes back to the same place.
// - Negate computes zero minus operand modulo its width, so zero stays zero.
// - Negate sets carry_flag when the operand is nonzero and clears it when zero.
// - Negate takes 3 clocks from a register, 10 from memory, 14 for a word in memory on a byte bus.
// - The no_operation opcode 90 is one byte long and only moves the instruction pointer on by one.
// - The no_operation leaves all registers, flags and memory untouched except the instruction pointer.
`timescale 1ns/1ps
module mnx_exec_unit
  import mnx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic narrow_bus_i,
  input wire logic start_i,
  input wire mnx_req_t req_i,
  input wire mnx_flags_t flags_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output mnx_res_t res_o,
  output mnx_flags_t flags_o
);
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    MNX_IDLE = 3'b001,
    MNX_RUN = 3'b010,
    MNX_DONE = 3'b100
  } mnx_state_t;

  // Operation class latched at the taking edge
  typedef enum logic [2:0] {
    MNX_OP_MUL = 3'b001,
    MNX_OP_NEG = 3'b010,
    MNX_OP_NOP = 3'b100
  } mnx_op_t;

  // Sequencer and captured request
  mnx_state_t state_q;
  mnx_state_t state_d;
  mnx_op_t op_q;
  mnx_op_t dec_op;
  mnx_req_t req_q;
  mnx_flags_t flags_q;
  // Write-back registers, one group per concern
  logic [15:0] mul_acc_q;
  logic mul_acc_we_q;
  logic [15:0] mul_dext_q;
  logic mul_dext_we_q;
  logic [15:0] neg_opnd_q;
  logic neg_opnd_we_q;
  logic neg_to_mem_q;
  logic [15:0] ip_next_q;
  logic ip_we_q;
  logic finish_now;
  // Decode, timing and datapath signals
  logic wide_q;
  logic timer_last;
  logic load_timer;
  logic [5:0] cyc_count;
  logic dec_mul;
  logic dec_neg;
  logic dec_nop;
  logic dec_wide;
  logic dec_ok;
  logic [31:0] product;
  logic [15:0] neg_res;
  logic [15:0] op_masked;
  logic [15:0] acc_masked;
  logic upper_nonzero;
  logic neg_zero_src;
  logic neg_ovf;
  logic neg_aux;
  logic neg_sign;
  logic neg_is_zero;
  logic [7:0] parity_byte;

  // Opcode decode
  always_comb begin
    dec_wide = (req_i.opcode == MNX_OPC_GRP_WORD);
    dec_mul = ((req_i.opcode == MNX_OPC_GRP_BYTE) || dec_wide) && (req_i.ext == MNX_EXT_MUL);
    dec_neg = ((req_i.opcode == MNX_OPC_GRP_BYTE) || dec_wide) && (req_i.ext == MNX_EXT_NEG);
    dec_nop = (req_i.opcode == MNX_OPC_NO_OP);
    dec_ok = dec_mul || dec_neg || dec_nop;
  end

  // Operation class of the incoming request, latched at the taking edge
  always_comb begin
    dec_op = MNX_OP_NOP;
    if (dec_mul) begin
      dec_op = MNX_OP_MUL;
    end else if (dec_neg) begin
      dec_op = MNX_OP_NEG;
    end
  end

  // Cycle count of the accepted instruction
  always_comb begin
    cyc_count = MNX_CYC_NOP;
    if (dec_neg) begin
      if (!req_i.is_mem) begin
        cyc_count = MNX_CYC_NEG_REG;
      end else if (dec_wide && narrow_bus_i) begin
        cyc_count = MNX_CYC_NEG_MEM_NARROW;
      end else begin
        cyc_count = MNX_CYC_NEG_MEM;
      end
    end else if (dec_mul) begin
      // Multiply takes the shortest count of its range; no data-dependent stretch
      if (!dec_wide) begin
        cyc_count = req_i.is_mem ? MNX_CYC_MULB_MEM : MNX_CYC_MULB_REG;
      end else if (!req_i.is_mem) begin
        cyc_count = MNX_CYC_MULW_REG;
      end else begin
        cyc_count = narrow_bus_i ? MNX_CYC_MULW_MEM_NARROW : MNX_CYC_MULW_MEM;
      end
    end
  end

  // Taken only when idle and decodable; a start while busy is simply dropped
  assign load_timer = (state_q == MNX_IDLE) && start_i && dec_ok;

  // Instruction length timer: last_o marks the write-back cycle
  mnx_cycle_timer u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .load_i(load_timer),
    .count_i(cyc_count),
    .last_o(timer_last)
  );

  // Sequencer state: busy through the whole instruction, one-cycle done after
  always_comb begin
    case (state_q)
      MNX_IDLE: state_d = load_timer ? MNX_RUN : MNX_IDLE;
      MNX_RUN: state_d = timer_last ? MNX_DONE : MNX_RUN;
      MNX_DONE: state_d = MNX_IDLE;
      default: state_d = MNX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= MNX_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // Capture the request so the sequencer may change its inputs while busy
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_q <= '0;
      op_q <= MNX_OP_NOP;
      wide_q <= 1'b0;
    end else if (ce_i && load_timer) begin
      req_q <= req_i;
      wide_q <= dec_wide;
      op_q <= dec_op;
    end
  end

  // Unsigned product: byte form zero extends the low byte of both factors
  always_comb begin
    op_masked = wide_q ? req_q.operand : {8'h00, req_q.operand[7:0]};
    acc_masked = wide_q ? req_q.acc : {8'h00, req_q.acc[7:0]};
    product = {16'h0000, op_masked} * {16'h0000, acc_masked};
    upper_nonzero = wide_q ? (product[31:16] != 16'h0000) : (product[15:8] != 8'h00);
  end

  // Negation as a subtraction from zero, flags taken from the same subtraction
  always_comb begin
    // Byte form keeps the upper result byte at zero
    neg_res = wide_q ? (16'h0000 - req_q.operand) : {8'h00, 8'h00 - req_q.operand[7:0]};
    neg_zero_src = wide_q ? (req_q.operand == 16'h0000) : (req_q.operand[7:0] == 8'h00);
    neg_ovf = wide_q ? (req_q.operand == 16'h8000) : (req_q.operand[7:0] == 8'h80);
    neg_aux = (req_q.operand[3:0] != 4'h0);
    neg_sign = wide_q ? neg_res[15] : neg_res[7];
    neg_is_zero = wide_q ? (neg_res == 16'h0000) : (neg_res[7:0] == 8'h00);
    parity_byte = neg_res[7:0];
  end

  // Results are written once, on the last timed cycle, so busy covers the write
  assign finish_now = (state_q == MNX_RUN) && timer_last;

  // Multiply write-back: both product halves land on the same edge as the flags
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mul_acc_q <= 16'h0000;
      mul_acc_we_q <= 1'b0;
      mul_dext_q <= 16'h0000;
      mul_dext_we_q <= 1'b0;
    end else if (ce_i) begin
      if (finish_now && (op_q == MNX_OP_MUL)) begin
        mul_acc_q <= product[15:0];
        mul_acc_we_q <= 1'b1;
        mul_dext_q <= product[31:16];
        mul_dext_we_q <= wide_q;
      end else begin
        mul_acc_q <= 16'h0000;
        mul_acc_we_q <= 1'b0;
        mul_dext_q <= 16'h0000;
        mul_dext_we_q <= 1'b0;
      end
    end
  end

  // Negate write-back goes to wherever the operand came from
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      neg_opnd_q <= 16'h0000;
      neg_opnd_we_q <= 1'b0;
      neg_to_mem_q <= 1'b0;
    end else if (ce_i) begin
      if (finish_now && (op_q == MNX_OP_NEG)) begin
        neg_opnd_q <= neg_res;
        neg_opnd_we_q <= 1'b1;
        neg_to_mem_q <= req_q.is_mem;
      end else begin
        neg_opnd_q <= 16'h0000;
        neg_opnd_we_q <= 1'b0;
        neg_to_mem_q <= 1'b0;
      end
    end
  end

  // Next pointer is offered for every instruction but written only by no_operation;
  // the sequencer steps the pointer itself for the longer encodings
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ip_next_q <= 16'h0000;
      ip_we_q <= 1'b0;
    end else if (ce_i) begin
      if (finish_now) begin
        ip_next_q <= req_q.ip + MNX_NOP_IP_STEP;
        ip_we_q <= (op_q == MNX_OP_NOP);
      end else begin
        ip_next_q <= 16'h0000;
        ip_we_q <= 1'b0;
      end
    end
  end

  // Flag output: no-op passes flags through untouched
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags_q <= '0;
    end else if (ce_i && state_q == MNX_RUN && timer_last) begin
      flags_q <= flags_i;
      case (op_q)
        // Multiply defines only carry and overflow; the rest pass through
        MNX_OP_MUL: begin
          flags_q.carry_flag <= upper_nonzero;
          flags_q.overflow_flag <= upper_nonzero;
        end
        MNX_OP_NEG: begin
          flags_q.carry_flag <= !neg_zero_src;
          flags_q.overflow_flag <= neg_ovf;
          flags_q.aux <= neg_aux;
          flags_q.sign <= neg_sign;
          flags_q.zero <= neg_is_zero;
          flags_q.parity <= ~^parity_byte;
        end
        // No-op and anything unexpected keep the incoming flags
        default: begin
          flags_q <= flags_i;
        end
      endcase
    end
  end

  // Unknown opcodes are flagged and not executed
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      illegal_o <= 1'b0;
    end else if (ce_i) begin
      illegal_o <= (state_q == MNX_IDLE) && start_i && !dec_ok;
    end
  end

  // Busy covers the done cycle, so a new start waits one more edge
  assign busy_o = (state_q != MNX_IDLE);
  assign done_o = (state_q == MNX_DONE);
  assign flags_o = flags_q;

  // Write-back bundle to the register file
  assign res_o = '{
    acc: mul_acc_q,
    acc_we: mul_acc_we_q,
    dext: mul_dext_q,
    dext_we: mul_dext_we_q,
    opnd: neg_opnd_q,
    opnd_we: neg_opnd_we_q,
    opnd_to_mem: neg_to_mem_q,
    ip: ip_next_q,
    ip_we: ip_we_q
  };
endmodule

/* tb/mnx_exec_monitor.sv */
// Checker for the multiply/negate/no-op unit, bound to its top module
`timescale 1ns/1ps
module mnx_exec_monitor
  import mnx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic narrow_bus_i,
  input wire logic start_i,
  input wire mnx_req_t req_i,
  input wire mnx_flags_t flags_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire mnx_res_t res_o,
  input wire mnx_flags_t flags_o
);
  mnx_req_t rq_q;
  logic mulb, mulw, negb, negw, nop;
  // Keep the taken request, since the bench may change req_i while busy
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) rq_q <= '0;
    else if (ce_i && start_i && !busy_o) rq_q <= req_i;
  end
  // Decode of the held request
  assign mulb = rq_q.opcode == MNX_OPC_GRP_BYTE && rq_q.ext == MNX_EXT_MUL;
  assign mulw = rq_q.opcode == MNX_OPC_GRP_WORD && rq_q.ext == MNX_EXT_MUL;
  assign negb = rq_q.opcode == MNX_OPC_GRP_BYTE && rq_q.ext == MNX_EXT_NEG;
  assign negw = rq_q.opcode == MNX_OPC_GRP_WORD && rq_q.ext == MNX_EXT_NEG;
  assign nop = rq_q.opcode == MNX_OPC_NO_OP;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Register-form negate taken, then three quiet cycles before the answer
  sequence s_take_neg_reg;
    ce_i && start_i && !busy_o && req_i.ext == MNX_EXT_NEG && !req_i.is_mem &&
      (req_i.opcode == MNX_OPC_GRP_BYTE || req_i.opcode == MNX_OPC_GRP_WORD);
  endsequence
  sequence s_answer_after_three;
    !done_o [*3] ##1 done_o;
  endsequence
  mulb_prod_a: assert property (done_o && mulb |-> res_o.acc_we && !res_o.dext_we &&
    res_o.acc == rq_q.operand[7:0] * rq_q.acc[7:0]) else $error("byte product wrong");
  mulw_prod_a: assert property (done_o && mulw |-> res_o.acc_we && res_o.dext_we &&
    {res_o.dext, res_o.acc} == rq_q.operand * rq_q.acc) else $error("word product wrong");
  mul_flags_a: assert property (done_o && (mulb || mulw) |->
    flags_o.carry_flag == (mulb ? (rq_q.operand[7:0] * rq_q.acc[7:0]) > 16'h00ff :
    ({16'h0000, rq_q.operand} * {16'h0000, rq_q.acc}) > 32'h0000ffff) &&
    flags_o.overflow_flag == flags_o.carry_flag) else $error("multiply flags wrong");
  neg_value_a: assert property (done_o && (negb || negw) |-> res_o.opnd_we &&
    res_o.opnd_to_mem == rq_q.is_mem && res_o.opnd == (negb ?
    {8'h00, 8'h00 - rq_q.operand[7:0]} : 16'h0000 - rq_q.operand)) else $error("negate wrong");
  neg_carry_a: assert property (done_o && (negb || negw) |-> flags_o.carry_flag ==
    (negb ? rq_q.operand[7:0] != 8'h00 : rq_q.operand != 16'h0000)) else $error("negate carry");
  neg_ovf_a: assert property (done_o && (negb || negw) |-> flags_o.overflow_flag ==
    (negb ? rq_q.operand[7:0] == 8'h80 : rq_q.operand == 16'h8000)) else $error("negate ovf");
  neg_time_a: assert property (s_take_neg_reg |=> s_answer_after_three)
    else $error("negate timing wrong");
  nop_effect_a: assert property (done_o && nop |-> res_o.ip_we &&
    res_o.ip == rq_q.ip + 16'h0001 && !res_o.acc_we && !res_o.dext_we && !res_o.opnd_we &&
    flags_o == flags_i) else $error("no-op changed state");
  busy_end_a: assert property ($fell(busy_o) |-> $past(done_o))
    else $error("busy dropped before done");
  freeze_hold_a: assert property (!ce_i |=> $stable(busy_o) && $stable(done_o) &&
    $stable(illegal_o) && $stable(res_o) && $stable(flags_o))
    else $error("outputs moved with clock enable low");
endmodule
bind mnx_exec_unit mnx_exec_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
  .narrow_bus_i(narrow_bus_i), .start_i(start_i), .req_i(req_i), .flags_i(flags_i),
  .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .res_o(res_o), .flags_o(flags_o));

/* tb/mnx_regfile_model.sv */
// Register file and flag store that takes the unit's write-backs
`timescale 1ns/1ps
module mnx_regfile_model
  import mnx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic done_i,
  input wire mnx_res_t res_i,
  input wire mnx_flags_t flags_i,
  output logic [15:0] acc_o,
  output logic [15:0] dext_o,
  output logic [15:0] opnd_o,
  output logic [15:0] ip_o,
  output mnx_flags_t flags_o
);
  // Each register moves only on its own strobe, flags on every done, so a stray strobe shows up later
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_o <= 16'h0000;
      dext_o <= 16'h0000;
      opnd_o <= 16'h0000;
      ip_o <= 16'h0000;
      flags_o <= '0;
    end else if (done_i) begin
      if (res_i.acc_we) acc_o <= res_i.acc;
      if (res_i.dext_we) dext_o <= res_i.dext;
      if (res_i.opnd_we) opnd_o <= res_i.opnd;
      if (res_i.ip_we) ip_o <= res_i.ip;
      flags_o <= flags_i;
    end
  end
endmodule

/* tb/mul_neg_nop_exec_unit_tb_top.sv */
// Self-checking bench for the multiply/negate/no-op unit
`timescale 1ns/1ps
module mul_neg_nop_exec_unit_tb_top;
  import mnx_pkg::*;
  typedef struct packed {
    logic [7:0] op; logic [2:0] ext; logic mem; logic [15:0] opnd; logic [15:0] acc;
    logic [15:0] e_acc; logic [15:0] e_dext; logic [15:0] e_opnd; logic cf; logic of; int n;
  } mnx_row_t;
  logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, narrow_bus_i = 1'b0, start_i = 1'b0;
  logic busy_o, done_o, illegal_o, ill;
  mnx_req_t req_i = '0;
  mnx_res_t res_o;
  mnx_flags_t flags_o, flg;
  logic [15:0] rf_acc, rf_dext, rf_opnd, rf_ip;
  int fail_count = 0, samples_checked = 0, cyc = 0, n;
  // Rows chain: later rows expect what earlier rows left in the register file
  mnx_row_t rows [8] = '{
    '{8'hf6, 3'h4, 1'b0, 16'h00ff, 16'h00ff, 16'hfe01, 16'h0000, 16'h0000, 1'b1, 1'b1, 26},
    '{8'hf6, 3'h4, 1'b1, 16'h1203, 16'hab05, 16'h000f, 16'h0000, 16'h0000, 1'b0, 1'b0, 32},
    '{8'hf7, 3'h4, 1'b0, 16'hffff, 16'hffff, 16'h0001, 16'hfffe, 16'h0000, 1'b1, 1'b1, 35},
    '{8'hf7, 3'h4, 1'b1, 16'h0020, 16'h012c, 16'h2580, 16'h0000, 16'h0000, 1'b0, 1'b0, 41},
    '{8'hf6, 3'h3, 1'b0, 16'h1280, 16'h5555, 16'h2580, 16'h0000, 16'h0080, 1'b1, 1'b1, 3},
    '{8'hf7, 3'h3, 1'b1, 16'h0640, 16'h5555, 16'h2580, 16'h0000, 16'hf9c0, 1'b1, 1'b0, 10},
    '{8'hf7, 3'h3, 1'b0, 16'h0000, 16'h5555, 16'h2580, 16'h0000, 16'h0000, 1'b0, 1'b0, 3},
    '{8'h90, 3'h0, 1'b0, 16'h1234, 16'h5555, 16'h2580, 16'h0000, 16'h0000, 1'b0, 1'b0, 3}};
  mnx_exec_unit uut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .narrow_bus_i(narrow_bus_i),
    .start_i(start_i), .req_i(req_i), .flags_i(flg), .busy_o(busy_o), .done_o(done_o),
    .illegal_o(illegal_o), .res_o(res_o), .flags_o(flags_o));
  mnx_regfile_model u_rf (.clk_i(clk_i), .reset_i(reset_i), .done_i(done_o), .res_i(res_o),
    .flags_i(flags_o), .acc_o(rf_acc), .dext_o(rf_dext), .opnd_o(rf_opnd), .ip_o(rf_ip),
    .flags_o(flg));
  always #5 clk_i = ~clk_i;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One request; n counts edges after the taking edge until done, 0 if it never comes
  task automatic go(input logic [7:0] op, input logic [2:0] ext, input logic mem,
    input logic [15:0] opnd, input logic [15:0] acc, input logic nb);
    @(posedge clk_i);
    start_i <= 1'b1;
    narrow_bus_i <= nb;
    req_i <= '{op, ext, mem, opnd, acc, 16'h0100};
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
    ill = illegal_o === 1'b1;
    n = 0;
    while (n < 60 && done_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 60) n = 0;
    @(posedge clk_i);
    #1;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].ext, rows[i].mem, rows[i].opnd, rows[i].acc, 1'b0);
      check("cycles", n, rows[i].n);
      check("acc", rf_acc, rows[i].e_acc);
      check("dext", rf_dext, rows[i].e_dext);
      check("opnd", rf_opnd, rows[i].e_opnd);
      check("carry", flg.carry_flag, rows[i].cf);
      check("ovf", flg.overflow_flag, rows[i].of);
    end
    check("ip", rf_ip, 32'h0101);
    // Byte-bus variant stretches only the word memory form
    go(8'hf7, MNX_EXT_NEG, 1'b1, 16'h8000, 16'h0000, 1'b1);
    check("narrow word", n, 14);
    check("ovf", flg.overflow_flag, 1'b1);
    go(8'hf6, MNX_EXT_NEG, 1'b1, 16'h0001, 16'h0000, 1'b1);
    check("narrow byte", n, 10);
    check("opnd", rf_opnd, 32'h00ff);
    go(8'hf7, MNX_EXT_MUL, 1'b1, 16'h0002, 16'h0003, 1'b1);
    check("narrow mul", n, 45);
    check("acc", rf_acc, 32'h0006);
    go(8'hf6, 3'h0, 1'b0, 16'h0001, 16'h0000, 1'b0);
    check("illegal", {ill, n[7:0]}, 32'h100);
    // Clock enable low for five edges freezes a byte multiply; done comes five edges later
    @(posedge clk_i);
    start_i <= 1'b1;
    req_i <= '{8'hf6, MNX_EXT_MUL, 1'b0, 16'h0010, 16'h0011, 16'h0100};
    @(posedge clk_i);
    start_i <= 1'b0;
    ce_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    ce_i <= 1'b1;
    n = 5;
    while (n < 60 && done_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    #1;
    check("frozen cycles", n, 31);
    check("frozen acc", rf_acc, 32'h0110);
    check("frozen carry", flg.carry_flag, 1'b1);
    // Reset in mid-multiply must abandon it cleanly
    @(posedge clk_i);
    start_i <= 1'b1;
    req_i <= '{8'hf7, MNX_EXT_MUL, 1'b0, 16'hffff, 16'hffff, 16'h0100};
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check("reset busy", {busy_o, done_o, rf_acc}, 32'h0);
    @(posedge clk_i);
    reset_i <= 1'b0;
    go(8'hf7, MNX_EXT_NEG, 1'b0, 16'h0002, 16'h0000, 1'b0);
    check("after reset", {n[7:0], rf_opnd}, 32'h03fffe);
    report_and_stop();
  end
endmodule
